// File: src/pea_accumulator.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - current code 12 bits, 102.4 mV full scale
// - supply code 12 bits, 102.4 V full scale
// - auxiliary code 12 bits, 2.048 V full scale
// - source field picks supply data, sense default
// - power is current code times voltage code
// - offset measured first after reset or control write
// - rate field sets calibration spacing
// - sequence 110 converts current continuously
// - control write refreshes offset then supply
// - current done: tick, add charge, add energy
// - other conversions accumulate with last values
// - result split high byte, low nibble zeroed
// - result registers update at conversion end
// - four byte tick counter
// - charge 36 bits, upper 32 visible
// - energy 48 bits, upper 32 visible
// - page read returns coherent bytes
// - accumulators preloadable, overflow flagged
// - busy while snapshot converts, then halt
// - snapshot end raises alert when enabled
// - snapshot leaves power and accumulators alone
// - gate pin inhibits accumulator updates
module pea_accumulator
	import pea_pkg::*;
(
	input  wire logic          clk,                 // 100 MHz
	input  wire logic          reset,               // async, active high
	input  wire logic          clk_en,              // freezes all state when low
	input  wire logic [7:0]    reg_addr,            // register byte address
	input  wire logic [7:0]    reg_wdata,           // write byte
	input  wire logic          reg_wr,              // write strobe
	input  wire logic          reg_rd,              // read strobe
	output logic      [7:0]    reg_rdata,           // read byte, cycle after strobe
	output pea_conv_req_t      conv_req,            // converter start and channel
	input  wire pea_conv_res_t conv_res,            // converter done and code
	input  wire logic          second_general_pin,  // accumulate gate pin
	output logic               alert                // flag and enable match, busy bit excluded
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	pea_seq_t              state_reg;
	pea_chan_t             chan_reg, chan_next;
	logic [7:0]            main_control_reg;
	logic                  gate_mode_reg;
	logic [7:0]            flag_reg;
	logic [7:0]            secondary_alert_enable_reg;
	logic                  supply_due_reg;
	logic [6:0]            cal_cnt_reg;
	logic [1:0]            rot_reg;
	logic [CODE_W-1:0]     current_reg, supply_reg, aux_reg, offset_reg;
	logic [POWER_W-1:0]    power_reg;
	logic [TIME_W-1:0]     time_reg;
	logic [CHARGE_W-1:0]   charge_reg;
	logic [ENERGY_W-1:0]   energy_reg;
	logic [31:0]           shadow_reg;
	logic [1:0]            shadow_grp_reg;
	logic [7:0]            rdata_reg;

	logic [2:0]            channel_sequence_field;
	logic [1:0]            supply_source_field, calibration_rate_field;
	logic                  snap_mode, ctrl_wr, done, fire, cur_done, snap_end;
	logic                  cal_due, conversion_busy_flag;
	pea_chan_t             data_chan, supply_chan;
	logic [CODE_W-1:0]     cur_now;
	logic [POWER_W-1:0]    pwr_now;
	logic [TIME_W:0]       time_sum;
	logic [CHARGE_W:0]     charge_sum;
	logic [ENERGY_W:0]     energy_sum;
	logic [TIME_W-1:0]     time_next;
	logic [CHARGE_W-1:0]   charge_next;
	logic [ENERGY_W-1:0]   energy_next;
	logic [31:0]           grp_val [4];
	logic [1:0]            grp_idx, byte_idx;
	logic                  in_acc;
	logic [7:0]            rd_val;

	assign channel_sequence_field = main_control_reg[CTRL_SEQ_LSB +: 3];
	assign supply_source_field    = main_control_reg[CTRL_SRC_LSB +: 2];
	assign calibration_rate_field = main_control_reg[CTRL_CAL_LSB +: 2];
	assign conversion_busy_flag   = flag_reg[FLAG_BUSY];
	assign snap_mode = (channel_sequence_field == SEQ_SNAP);
	assign ctrl_wr   = reg_wr && (reg_addr == OFF_CTRL);
	assign done      = (state_reg == SQ_WAIT) && conv_res.done && !ctrl_wr;
	assign snap_end  = done && snap_mode && (chan_reg != CH_OFFSET);

	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	assign conv_req = '{start: (state_reg == SQ_ISSUE), channel: chan_reg};

	always_comb begin
		unique case (supply_source_field)
			SRC_SUPPLY: supply_chan = CH_SUPPLY;
			SRC_AUX:    supply_chan = CH_AUX;
			SRC_SENSE:  supply_chan = CH_SENSE;
			default:    supply_chan = snap_mode ? CH_CURRENT : CH_SENSE;
		endcase
		if (channel_sequence_field == SEQ_CURRENT) begin
			data_chan = CH_CURRENT;
		end else begin
			unique case (rot_reg)
				2'h1:    data_chan = supply_chan;
				2'h2:    data_chan = CH_AUX;
				default: data_chan = CH_CURRENT;
			endcase
		end
		unique case (calibration_rate_field)
			CAL_EVERY: cal_due = 1'b1;
			CAL_16:    cal_due = (cal_cnt_reg == 7'(CAL_MID_N - 1));
			CAL_SLOW:  cal_due = (cal_cnt_reg == 7'(CAL_SLOW_N - 1));
			default:   cal_due = 1'b0;
		endcase
		if (chan_reg == CH_OFFSET) begin
			chan_next = (supply_due_reg || snap_mode) ? supply_chan : data_chan;
		end else if (cal_due) begin
			chan_next = CH_OFFSET;
		end else begin
			chan_next = data_chan;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg      <= SQ_ISSUE;
			chan_reg       <= CH_OFFSET;
			supply_due_reg <= 1'b1;
			cal_cnt_reg    <= '0;
			rot_reg        <= '0;
		end else if (clk_en) begin
			if (ctrl_wr) begin
				state_reg      <= SQ_ISSUE;
				chan_reg       <= CH_OFFSET;
				supply_due_reg <= 1'b1;
				cal_cnt_reg    <= '0;
				rot_reg        <= '0;
			end else begin
				unique case (state_reg)
					SQ_ISSUE: state_reg <= SQ_WAIT;
					SQ_WAIT: begin
						if (snap_end) begin
							state_reg <= SQ_HALT;
						end else if (done) begin
							state_reg <= SQ_ISSUE;
							chan_reg  <= chan_next;
							if (chan_reg == CH_OFFSET) begin
								supply_due_reg <= 1'b0;
							end
							// counts completed non-cal conversions, saturating
							if (chan_reg == CH_OFFSET) begin
								cal_cnt_reg <= '0;
							end else if (cal_cnt_reg != 7'(CAL_SLOW_N - 1)) begin
								cal_cnt_reg <= cal_cnt_reg + 7'(1);
							end
							if (chan_next == data_chan && chan_reg != CH_OFFSET) begin
								rot_reg <= (rot_reg == 2'h2 || (rot_reg == 2'h1 && !channel_sequence_field[0]))
									? 2'h0 : rot_reg + 2'h1;
							end
						end
					end
					SQ_HALT: state_reg <= SQ_HALT;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// result registers, codes already scaled by the converter
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			current_reg <= '0;
			supply_reg  <= '0;
			aux_reg     <= '0;
			offset_reg  <= '0;
		end else if (clk_en && done) begin
			unique case (chan_reg)
				CH_CURRENT: current_reg <= conv_res.code;
				CH_OFFSET:  offset_reg  <= conv_res.code;
				CH_SENSE, CH_SUPPLY: supply_reg <= conv_res.code;
				CH_AUX: begin
					aux_reg <= conv_res.code;
					if (supply_source_field == SRC_AUX) begin
						supply_reg <= conv_res.code;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// multiplier and accumulators
	// ------------------------------------------------------------
	// snapshot conversions never tick, so the totals stay untouched
	assign fire     = done && !snap_mode && (!gate_mode_reg || second_general_pin);
	assign cur_done = done && !snap_mode && (chan_reg == CH_CURRENT);
	assign cur_now  = cur_done ? conv_res.code : current_reg;
	assign pwr_now  = cur_done ? conv_res.code * supply_reg : power_reg;
	assign time_sum   = {1'b0, time_reg} + 33'h0_0000_0001;
	assign charge_sum = {1'b0, charge_reg} + {25'h000_0000, cur_now};
	assign energy_sum = {1'b0, energy_reg} + {25'h000_0000, pwr_now};

	always_comb begin
		time_next   = fire ? time_sum[TIME_W-1:0] : time_reg;
		charge_next = fire ? charge_sum[CHARGE_W-1:0] : charge_reg;
		energy_next = fire ? energy_sum[ENERGY_W-1:0] : energy_reg;
		for (int i = 0; i < 4; i++) begin
			if (reg_wr && reg_addr == 8'(OFF_TIME + i)) begin
				time_next[31-8*i -: 8] = reg_wdata;
			end
			if (reg_wr && reg_addr == 8'(OFF_CHARGE + i)) begin
				charge_next[35-8*i -: 8] = reg_wdata;
			end
			if (reg_wr && reg_addr == 8'(OFF_ENERGY + i)) begin
				energy_next[47-8*i -: 8] = reg_wdata;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			power_reg  <= '0;
			time_reg   <= '0;
			charge_reg <= '0;
			energy_reg <= '0;
		end else if (clk_en) begin
			if (cur_done) begin
				power_reg <= pwr_now;
			end
			time_reg   <= time_next;
			charge_reg <= charge_next;
			energy_reg <= energy_next;
		end
	end

	// ------------------------------------------------------------
	// control, flags and alert
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			main_control_reg           <= CTRL_RESET;
			gate_mode_reg              <= 1'b0;
			secondary_alert_enable_reg <= '0;
		end else if (clk_en && reg_wr) begin
			if (reg_addr == OFF_CTRL) begin
				main_control_reg <= reg_wdata;
			end
			if (reg_addr == OFF_CONFIG) begin
				gate_mode_reg <= reg_wdata[0];
			end
			if (reg_addr == OFF_ALERT_EN) begin
				secondary_alert_enable_reg <= reg_wdata;
			end
		end
	end

	// write one clears all but busy; a same-cycle hardware set wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flag_reg <= '0;
		end else if (clk_en) begin
			for (int b = 0; b < 8; b++) begin
				if (reg_wr && reg_addr == OFF_FLAGS && reg_wdata[b] && b != FLAG_BUSY) begin
					flag_reg[b] <= 1'b0;
				end
			end
			if (fire && time_sum[TIME_W]) flag_reg[FLAG_TIME] <= 1'b1;
			if (fire && charge_sum[CHARGE_W]) flag_reg[FLAG_CHARGE] <= 1'b1;
			if (fire && energy_sum[ENERGY_W]) flag_reg[FLAG_ENERGY] <= 1'b1;
			if (snap_end) begin
				flag_reg[FLAG_BUSY] <= 1'b0;
				flag_reg[FLAG_SNAP] <= 1'b1;
			end
			if (ctrl_wr) begin
				flag_reg[FLAG_BUSY] <= (reg_wdata[CTRL_SEQ_LSB +: 3] == SEQ_SNAP);
			end
		end
	end

	assign alert = |(flag_reg & secondary_alert_enable_reg & 8'h87);

	// ------------------------------------------------------------
	// read path with page shadow
	// ------------------------------------------------------------
	assign grp_val[0] = {power_reg, 8'h00};
	assign grp_val[1] = time_reg;
	assign grp_val[2] = charge_reg[CHARGE_W-1 -: 32];
	assign grp_val[3] = energy_reg[ENERGY_W-1 -: 32];
	assign in_acc   = (reg_addr >= OFF_POWER) && (reg_addr <= OFF_ACC_END);
	assign grp_idx  = 2'((reg_addr - OFF_POWER) >> 2);
	assign byte_idx = reg_addr[1:0];

	always_comb begin
		rd_val = 8'h00;
		if (in_acc) begin
			// bytes after the first come from the copy taken at the first
			if (byte_idx == 2'h0 || shadow_grp_reg != grp_idx) begin
				rd_val = grp_val[grp_idx][31-8*byte_idx -: 8];
			end else begin
				rd_val = shadow_reg[31-8*byte_idx -: 8];
			end
		end else begin
			unique case (reg_addr)
				OFF_CTRL:        rd_val = main_control_reg;
				OFF_CONFIG:      rd_val = {7'h00, gate_mode_reg};
				OFF_FLAGS:       rd_val = flag_reg;
				OFF_ALERT_EN:    rd_val = secondary_alert_enable_reg;
				OFF_CURRENT:     rd_val = current_reg[11:4];
				OFF_CURRENT + 1: rd_val = {current_reg[3:0], 4'h0};
				OFF_SUPPLY:      rd_val = supply_reg[11:4];
				OFF_SUPPLY + 1:  rd_val = {supply_reg[3:0], 4'h0};
				OFF_AUX:         rd_val = aux_reg[11:4];
				OFF_AUX + 1:     rd_val = {aux_reg[3:0], 4'h0};
				OFF_OFFSET:      rd_val = offset_reg[11:4];
				OFF_OFFSET + 1:  rd_val = {offset_reg[3:0], 4'h0};
				default:         rd_val = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_reg      <= '0;
			shadow_reg     <= '0;
			shadow_grp_reg <= '0;
		end else if (clk_en) begin
			rdata_reg <= reg_rd ? rd_val : 8'h00;
			if (reg_rd && in_acc && byte_idx == 2'h0) begin
				shadow_reg     <= grp_val[grp_idx];
				shadow_grp_reg <= grp_idx;
			end
		end
	end

	assign reg_rdata = rdata_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_busy_on_snap: assert property (clk_en && ctrl_wr && reg_wdata[2:0] == SEQ_SNAP |=> conversion_busy_flag)
		else $error("busy not set by snapshot write");
	a_busy_end_halt: assert property (clk_en && snap_end |=> !conversion_busy_flag && state_reg == SQ_HALT)
		else $error("snapshot end did not halt");
	a_cal_first: assert property (clk_en && ctrl_wr |=> conv_req.start && conv_req.channel == CH_OFFSET)
		else $error("offset not converted first");
	a_time_tick: assert property (clk_en && fire && !reg_wr |=> time_reg == $past(time_reg) + 32'h0000_0001)
		else $error("tick counter missed");
	a_power_prod: assert property (clk_en && cur_done |=> power_reg == $past(conv_res.code) * $past(supply_reg))
		else $error("power word wrong");
	a_low_nibble: assert property (clk_en && reg_rd && reg_addr == OFF_CURRENT + 1 |=> reg_rdata[3:0] == 4'h0)
		else $error("low nibble not zero");
	a_snap_frozen: assert property (clk_en && snap_mode && !reg_wr |=> $stable(time_reg) && $stable(energy_reg))
		else $error("snapshot changed totals");
	a_gate_hold: assert property (clk_en && gate_mode_reg && !second_general_pin && !reg_wr |=> $stable(charge_reg))
		else $error("gate did not inhibit");
	a_snap_alert: assert property (clk_en && snap_end && secondary_alert_enable_reg[FLAG_SNAP] |=> alert)
		else $error("snapshot alert missing");
	a_supply_after: assert property (clk_en && done && chan_reg == CH_OFFSET && supply_due_reg && !snap_mode
		|=> conv_req.channel == supply_chan)
		else $error("supply not refreshed after offset");

	c_snapshot:   cover property (snap_end);
	c_overflow:   cover property (fire && time_sum[TIME_W]);
	c_page_read:  cover property (reg_rd && in_acc && byte_idx == 2'h0 ##1 reg_rd && in_acc && byte_idx == 2'h1);
	c_continuous: cover property (cur_done && channel_sequence_field == SEQ_CURRENT);
endmodule // pea_accumulator
`default_nettype wire

// File: src/pea_pkg.sv
package pea_pkg;
	// ------------------------------------------------------------
	// converter scaling, one code step is full scale / 4096
	// ------------------------------------------------------------
	localparam int CODE_W          = 12;
	localparam int FS_CURRENT_UV   = 102400;
	localparam int FS_SUPPLY_MV    = 102400;
	localparam int FS_AUX_UV       = 2048000;
	localparam int TICK_US_X1000   = 16395000;
	localparam int POWER_W         = 24;
	localparam int TIME_W          = 32;
	localparam int CHARGE_W        = 36;
	localparam int ENERGY_W        = 48;
	localparam int CAL_SLOW_N      = 128;
	localparam int CAL_MID_N       = 16;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_CONFIG   = 8'h01;
	localparam logic [7:0] OFF_FLAGS    = 8'h02;
	localparam logic [7:0] OFF_ALERT_EN = 8'h03;
	localparam logic [7:0] OFF_POWER    = 8'h04;
	localparam logic [7:0] OFF_TIME     = 8'h08;
	localparam logic [7:0] OFF_CHARGE   = 8'h0C;
	localparam logic [7:0] OFF_ENERGY   = 8'h10;
	localparam logic [7:0] OFF_ACC_END  = 8'h13;
	localparam logic [7:0] OFF_CURRENT  = 8'h14;
	localparam logic [7:0] OFF_SUPPLY   = 8'h16;
	localparam logic [7:0] OFF_AUX      = 8'h18;
	localparam logic [7:0] OFF_OFFSET   = 8'h1A;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_SEQ_LSB = 0;
	localparam int CTRL_SRC_LSB = 3;
	localparam int CTRL_CAL_LSB = 5;
	localparam int FLAG_TIME    = 0;
	localparam int FLAG_CHARGE  = 1;
	localparam int FLAG_ENERGY  = 2;
	localparam int FLAG_BUSY    = 3;
	localparam int FLAG_SNAP    = 7;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [2:0] SEQ_CURRENT = 3'h6;
	localparam logic [2:0] SEQ_SNAP    = 3'h7;
	localparam logic [1:0] SRC_SENSE   = 2'h0;
	localparam logic [1:0] SRC_SUPPLY  = 2'h1;
	localparam logic [1:0] SRC_AUX     = 2'h2;
	localparam logic [1:0] CAL_EVERY   = 2'h0;
	localparam logic [1:0] CAL_16      = 2'h1;
	localparam logic [1:0] CAL_SLOW    = 2'h2;

	typedef enum logic [2:0] {CH_CURRENT, CH_OFFSET, CH_SENSE, CH_SUPPLY, CH_AUX} pea_chan_t;
	typedef enum logic [1:0] {SQ_ISSUE, SQ_WAIT, SQ_HALT} pea_seq_t;

	typedef struct packed {
		logic      start;
		pea_chan_t channel;
	} pea_conv_req_t;

	typedef struct packed {
		logic              done;
		logic [CODE_W-1:0] code;
	} pea_conv_res_t;
endpackage

// File: testbench/pea_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
module pea_conv_model
	import pea_pkg::*;
(
	input  wire logic          clk,       // bench clock
	input  wire logic          reset,     // async, active high
	input  wire pea_conv_req_t conv_req,  // start and channel from block
	output var  pea_conv_res_t conv_res,  // done pulse and code
	input  wire logic [11:0]   cur_code,  // current result
	input  wire logic [11:0]   sup_code,  // supply or sense result
	input  wire logic [11:0]   aux_code,  // auxiliary result
	input  wire logic [11:0]   off_code,  // offset result
	input  wire logic          slow,      // long conversions when high
	input  var  int            budget,    // total dones allowed so far
	output var  int            done_cnt   // dones given so far
);
	logic      busy_reg;
	pea_chan_t chan_reg;
	int        age_reg;

	// ------------------------------------------------------------
	// converter
	// ------------------------------------------------------------
	function automatic logic [11:0] pick(input pea_chan_t ch);
		case (ch)
			CH_CURRENT: return cur_code;
			CH_OFFSET:  return off_code;
			CH_AUX:     return aux_code;
			default:    return sup_code;
		endcase
	endfunction

	// a new start aborts any conversion in flight, as a restarted sequence would
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy_reg <= 1'b0;
			chan_reg <= CH_OFFSET;
			age_reg  <= 0;
			done_cnt <= 0;
			conv_res <= '0;
		end else begin
			conv_res.done <= 1'b0;
			// idle code keeps toggling so a stale value is never mistaken for data
			conv_res.code <= ~conv_res.code;
			if (conv_req.start) begin
				busy_reg <= 1'b1;
				chan_reg <= conv_req.channel;
				age_reg  <= 0;
			end else if (busy_reg && age_reg >= (slow ? 30 : 4) && done_cnt < budget) begin
				conv_res.done <= 1'b1;
				conv_res.code <= pick(chan_reg);
				busy_reg      <= 1'b0;
				done_cnt      <= done_cnt + 1;
			end else if (busy_reg) begin
				age_reg <= age_reg + 1;
			end
		end
	end
endmodule // pea_conv_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pea_pkg::*;
	typedef struct {
		string      name;
		logic [7:0] exp;
	} pea_note_t;

	logic          clk;
	logic          reset;
	logic          clk_en;
	logic [7:0]    reg_addr;
	logic [7:0]    reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	logic [7:0]    reg_rdata;
	pea_conv_req_t conv_req;
	pea_conv_res_t conv_res;
	logic          pin;
	logic          alert;
	logic          slow;
	logic          rd_d = 1'b0;
	logic [11:0]   cur, sup, aux, off;
	logic [23:0]   pw;
	logic [35:0]   chg;
	logic [47:0]   nrg;
	int            budget;
	int            done_cnt;
	int            n_errors;
	int            n_checks;
	int            seed;
	int            i, k, n0, a, b;
	pea_chan_t     log_q[$];
	pea_note_t     note_q[$];

	pea_accumulator pea_accumulator_inst (
		.clk                (clk),
		.reset              (reset),
		.clk_en             (clk_en),
		.reg_addr           (reg_addr),
		.reg_wdata          (reg_wdata),
		.reg_wr             (reg_wr),
		.reg_rd             (reg_rd),
		.reg_rdata          (reg_rdata),
		.conv_req           (conv_req),
		.conv_res           (conv_res),
		.second_general_pin (pin),
		.alert              (alert)
	);

	pea_conv_model pea_conv_model_inst (
		.clk      (clk),
		.reset    (reset),
		.conv_req (conv_req),
		.conv_res (conv_res),
		.cur_code (cur),
		.sup_code (sup),
		.aux_code (aux),
		.off_code (off),
		.slow     (slow),
		.budget   (budget),
		.done_cnt (done_cnt)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// bus tasks and checking
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= ad;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [7:0] e, input string name);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd   <= 1'b1;
		note_q.push_back('{name, e});
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	// base byte first so the whole group is captured in one page
	task automatic rd4(input logic [7:0] ad, input logic [31:0] v, input string name);
		for (int j = 0; j < 4; j++) rd(ad + 8'(j), v[31 - 8*j -: 8], name);
	endtask

	task automatic run_conv(input int n);
		int tgt;
		int w;
		tgt = budget + n;
		w = 0;
		@(posedge clk);
		budget <= tgt;
		while (done_cnt != tgt && w < 5000) begin
			@(posedge clk);
			w++;
		end
		chk("conversion count", 48'(done_cnt), 48'(tgt));
		repeat (3) @(posedge clk);
	endtask

	task test_done;
		if (n_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// monitors
	// ------------------------------------------------------------
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (!reset && conv_req.start === 1'b1) log_q.push_back(conv_req.channel);
	end

	always @(negedge clk) begin : read_watch
		pea_note_t nt;
		if (rd_d === 1'b1 && note_q.size() > 0) begin
			nt = note_q.pop_front();
			chk(nt.name, 48'(reg_rdata), 48'(nt.exp));
		end
	end

	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		test_done;
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 68934;
		reset = 1'b1;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		pin = 1'b0;
		slow = 1'b0;
		budget = 0;
		n_errors = 0;
		n_checks = 0;
		cur = 12'($random(seed)) | 12'h001;
		sup = 12'($random(seed));
		aux = 12'($random(seed));
		off = 12'($random(seed));
		pw = 24'(cur) * 24'(sup);
		chg = 36'(cur) * 36'd20;
		nrg = 48'(pw) * 48'd20;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		rd(OFF_CTRL, CTRL_RESET, "control reset");
		rd(OFF_FLAGS, 8'h00, "flags reset");
		rd(8'h1F, 8'h00, "unmapped read");
		rd(8'h07, 8'h00, "power pad byte");
		// offset restart with continuous current and no further calibration
		wr(OFF_CTRL, 8'h66);
		run_conv(22);
		chk("first channel", 48'(log_q[0]), 48'(CH_OFFSET));
		chk("channel after write", 48'(log_q[1]), 48'(CH_OFFSET));
		chk("supply channel", 48'(log_q[2]), 48'(CH_SENSE));
		chk("current channel", 48'(log_q[3]), 48'(CH_CURRENT));
		chk("current repeat", 48'(log_q[4]), 48'(CH_CURRENT));
		rd(OFF_POWER, pw[23:16], "power high");
		rd(OFF_POWER + 8'h01, pw[15:8], "power mid");
		rd(OFF_POWER + 8'h02, pw[7:0], "power low");
		rd4(OFF_TIME, 32'd22, "time count");
		rd4(OFF_CHARGE, chg[35:4], "charge");
		rd4(OFF_ENERGY, nrg[47:16], "energy");
		rd(OFF_CURRENT, cur[11:4], "current high");
		rd(OFF_CURRENT + 8'h01, {cur[3:0], 4'h0}, "current low");
		rd(OFF_SUPPLY, sup[11:4], "supply high");
		rd(OFF_SUPPLY + 8'h01, {sup[3:0], 4'h0}, "supply low");
		rd(OFF_OFFSET, off[11:4], "offset high");
		// preload time to its top so one tick overflows it
		for (i = 0; i < 4; i++) wr(OFF_TIME + 8'(i), 8'hFF);
		wr(OFF_ALERT_EN, 8'h01);
		run_conv(1);
		rd4(OFF_TIME, 32'd0, "time wrap");
		rd(OFF_FLAGS, 8'h01, "time overflow flag");
		chk("overflow alert", 48'(alert), 48'd1);
		wr(OFF_FLAGS, 8'h01);
		@(negedge clk);
		chk("alert cleared", 48'(alert), 48'd0);
		// gate closed, then open
		wr(OFF_CONFIG, 8'h01);
		run_conv(3);
		rd4(OFF_TIME, 32'd0, "gated time");
		@(posedge clk);
		pin <= 1'b1;
		run_conv(2);
		rd4(OFF_TIME, 32'd2, "open gate time");
		// snapshot of the auxiliary channel with completion alert
		wr(OFF_ALERT_EN, 8'h80);
		n0 = log_q.size();
		wr(OFF_CTRL, 8'h77);
		rd(OFF_FLAGS, 8'h08, "busy flag");
		run_conv(2);
		repeat (60) @(posedge clk);
		chk("snapshot halt", 48'(log_q.size()), 48'(n0 + 2));
		chk("snapshot channel", 48'(log_q[n0 + 1]), 48'(CH_AUX));
		rd(OFF_FLAGS, 8'h80, "snapshot done flag");
		chk("snapshot alert", 48'(alert), 48'd1);
		rd(OFF_AUX, aux[11:4], "aux high");
		rd(OFF_AUX + 8'h01, {aux[3:0], 4'h0}, "aux low");
		rd4(OFF_TIME, 32'd2, "snapshot time");
		rd(OFF_POWER, pw[23:16], "snapshot power");
		wr(OFF_FLAGS, 8'h80);
		// rotation through supply pin and auxiliary, no calibration
		n0 = log_q.size();
		wr(OFF_CTRL, 8'h6D);
		run_conv(6);
		chk("rotate offset", 48'(log_q[n0]), 48'(CH_OFFSET));
		chk("rotate supply", 48'(log_q[n0 + 1]), 48'(CH_SUPPLY));
		chk("rotate current", 48'(log_q[n0 + 2]), 48'(CH_CURRENT));
		chk("rotate aux", 48'(log_q[n0 + 4]), 48'(CH_AUX));
		rd(OFF_SUPPLY, sup[11:4], "supply pin high");
		// calibration between every conversion
		n0 = log_q.size();
		wr(OFF_CTRL, 8'h06);
		run_conv(8);
		k = 0;
		for (i = n0 + 2; i < log_q.size() - 1; i++)
			if (log_q[i] == CH_CURRENT && log_q[i + 1] == CH_CURRENT) k++;
		chk("calibrate every other", 48'(k), 48'd0);
		// calibration every sixteen, slow conversions
		@(posedge clk);
		slow <= 1'b1;
		n0 = log_q.size();
		wr(OFF_CTRL, 8'h26);
		run_conv(40);
		k = 0;
		a = -1;
		b = -1;
		for (i = n0 + 1; i < log_q.size(); i++)
			if (log_q[i] == CH_OFFSET) begin
				k++;
				if (k == 1) a = i;
				if (k == 2) b = i;
			end
		chk("calibration spacing", 48'(b - a - 1), 48'd16);
		// a write while the enable is low must not land
		@(posedge clk);
		clk_en <= 1'b0;
		wr(OFF_ALERT_EN, 8'h55);
		@(posedge clk);
		clk_en <= 1'b1;
		rd(OFF_ALERT_EN, 8'h80, "frozen write");
		test_done;
	end
endmodule // tb
`default_nettype wire
